// ### core/adcc_defs.svh
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
// Register addresses on the plain register port.
`define ADCC_ADDR_RES_LO 4'h0
`define ADCC_ADDR_RES_HI 4'h1
`define ADCC_ADDR_MAIN 4'h2
`define ADCC_ADDR_SRC 4'h3
`define ADCC_ADDR_REF 4'h4
`define ADCC_ADDR_BGAP 4'h5
`define ADCC_ADDR_IRQ_STAT 4'h6
`define ADCC_ADDR_IRQ_MASK 4'h7
// Field positions of the main control register.
`define ADCC_MAIN_START 7
`define ADCC_MAIN_BUSY 6
`define ADCC_MAIN_EN 5
`define ADCC_MAIN_ALIGN 4
// Write masks of the configuration registers (unimplemented bits zero).
`define ADCC_SRC_MASK 8'hF7
`define ADCC_REF_MASK 8'h9F
`define ADCC_BGAP_MASK 8'h01
// Reset values.
`define ADCC_MAIN_RST 8'h00
`define ADCC_CFG_RST 8'h00
// Conversion length in converter clock periods.
`define ADCC_CONV_TICKS 5'h10
`endif

// ### core/adcc_pkg.sv
package adcc_pkg;
    // Conversion sequencer states.
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_ARMED, ADCC_CONV} adcc_state_type;
    // Register port request.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcc_req_type;
    // Analog front-end selection.
    typedef struct packed {
        logic [15:0] ext_connect;
        logic internal_sel;
        logic [2:0] internal_code;
    } adcc_mux_type;
endpackage : adcc_pkg

// ### core/adcc_top.sv
`timescale 1ns/1ps
`include "adcc_defs.svh"
//////////////////////////////////////////////////////////////////////////////
module adcc_top
    import adcc_pkg::*;
(
    input wire logic clk, // System clock, 200 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire adcc_req_type req, // Register port request.
    output logic [7:0] rdata, // Read data, one cycle after read.
    input wire logic [11:0] conv_data, // Result from the analog core.
    input wire logic [15:0] pin_analog_cfg, // Pins configured as inputs.
    output adcc_mux_type mux, // Analog multiplexer controls.
    output logic [15:0] pin_digital_off, // Digital function removed.
    output logic [15:0] pin_pullup_off, // Pull-high detached.
    output logic conv_power, // Converter powered.
    output logic conv_sample, // Converter clock enable pulse.
    output logic [7:0] ref_cfg, // Reference and gain settings.
    output logic bandgap_enable, // Bandgap reference enable.
    output logic irq // Level interrupt.
);

    //////////////////////////////////////////////////////////////////////////
    // Registers and internal state.
    logic [7:0] main_reg; // Start, enable, alignment, channel.
    logic [7:0] src_reg; // Input source and clock divider.
    logic [7:0] ref_reg; // Reference and gain configuration.
    logic [7:0] bgap_reg; // Bandgap control.
    logic busy_reg; // Conversion in progress.
    logic [11:0] result_reg; // Stored 12-bit result.
    logic irq_stat_reg; // Sticky completion status.
    logic irq_mask_reg; // Completion interrupt mask.
    logic [6:0] div_reg; // Conversion clock prescaler.
    logic [4:0] tick_reg; // Converter clock periods counted.
    adcc_state_type state_reg; // Sequencer state.
    logic start_bit; // Current start bit.
    logic start_next; // Start bit after this cycle's write.
    logic wr_main; // Write to main control this cycle.
    logic tick; // Conversion clock enable pulse.
    logic done; // Conversion completes this cycle.
    logic [3:0] source; // Input source field.
    logic [2:0] ckdiv; // Clock divider field.
    logic [6:0] div_limit; // Prescaler terminal count.
    logic [7:0] res_lo; // Presented low byte.
    logic [7:0] res_hi; // Presented high byte.
    logic abort; // Start bit rising edge in this cycle.

    //////////////////////////////////////////////////////////////////////////
    // Start bit edges.
    // The sequencer compares the stored start bit with the value that this
    // cycle's write is about to store, so an edge is seen in the very cycle
    // of the write and no extra register stage is needed.
    assign start_bit = main_reg[`ADCC_MAIN_START];
    assign wr_main = req.wr && req.addr == `ADCC_ADDR_MAIN;
    assign start_next = wr_main ? req.wdata[`ADCC_MAIN_START] : start_bit;
    // A rising edge resets the converter, even on its very last period.
    assign abort = !start_bit && start_next;
    // Fields of the input and clock select register.
    assign source = src_reg[7:4];
    assign ckdiv = src_reg[2:0];

    //////////////////////////////////////////////////////////////////////////
    // Control register writes.
    // Writes land at the edge that samples the strobe, so a read issued
    // in the next cycle already returns the new value.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            main_reg <= `ADCC_MAIN_RST;
            src_reg <= `ADCC_CFG_RST;
            ref_reg <= `ADCC_CFG_RST;
            bgap_reg <= `ADCC_CFG_RST;
            irq_mask_reg <= 1'b0;
        end
        else if (req.wr)
        begin
            // Address decode; unmapped and read-only addresses ignore writes.
            if (req.addr == `ADCC_ADDR_MAIN)
            begin
                // busy not writable
                // Start, enable, alignment and channel fields are stored.
                main_reg <= req.wdata & 8'hBF;
            end
            else if (req.addr == `ADCC_ADDR_SRC)
            begin
                // Unimplemented bit 3 stays zero.
                src_reg <= req.wdata & `ADCC_SRC_MASK;
            end
            else if (req.addr == `ADCC_ADDR_REF)
            begin
                // Unimplemented bits 6 and 5 stay zero.
                ref_reg <= req.wdata & `ADCC_REF_MASK;
            end
            else if (req.addr == `ADCC_ADDR_BGAP)
            begin
                // Only the enable bit exists.
                bgap_reg <= req.wdata & `ADCC_BGAP_MASK;
            end
            else if (req.addr == `ADCC_ADDR_IRQ_MASK)
            begin
                // Single completion mask bit.
                irq_mask_reg <= req.wdata[0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Conversion clock prescaler.
    // The terminal count is one less than the ratio; the ratio of 128
    // wraps to zero in seven bits, so that code is handled on its own.
    // divide by power
    always_comb
    begin
        div_limit = 7'(8'h01 << ckdiv) - 7'h01;
        if (ckdiv == 3'h7)
        begin
            div_limit = 7'h7F;
        end
    end

    assign tick = state_reg == ADCC_CONV && div_reg >= div_limit;

    // Prescaler runs only while converting so every conversion starts aligned.
    always_ff @(posedge clk)
    begin
        if (!rst_n || state_reg != ADCC_CONV || tick)
        begin
            div_reg <= 7'h00;
        end
        else
        begin
            div_reg <= div_reg + 7'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.
    // Idle waits for a start bit rising edge, armed waits for the falling
    // edge, and converting counts converter periods. Busy is high only in
    // the converting state.
    // The last converter period ends the conversion, unless a start bit
    // rising edge in the same cycle resets the converter first; then no
    // result is taken and no completion is flagged.
    assign done = tick && tick_reg == `ADCC_CONV_TICKS - 5'h01 && !abort;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ADCC_IDLE;
            busy_reg <= 1'b0;
            tick_reg <= 5'h00;
        end
        else if (!main_reg[`ADCC_MAIN_EN])
        begin
            // Switching off drops any conversion in flight.
            // disabled converter idles
            state_reg <= ADCC_IDLE;
            busy_reg <= 1'b0;
            tick_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                // A rising edge aborts a running conversion as well.
                ADCC_IDLE, ADCC_CONV:
                begin
                    if (!start_bit && start_next)
                    begin
                        state_reg <= ADCC_ARMED;
                        busy_reg <= 1'b0;
                        tick_reg <= 5'h00;
                    end
                    else if (state_reg == ADCC_CONV && tick)
                    begin
                        if (done)
                        begin
                            state_reg <= ADCC_IDLE;
                            busy_reg <= 1'b0;
                        end
                        tick_reg <= tick_reg + 5'h01;
                    end
                end
                // Start held high keeps the converter in reset.
                ADCC_ARMED:
                begin
                    if (!start_next)
                    begin
                        state_reg <= ADCC_CONV;
                        busy_reg <= 1'b1;
                        tick_reg <= 5'h00;
                    end
                end
                default:
                begin
                    state_reg <= ADCC_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Result capture.
    // The analog core's word is taken only on a finished conversion, so
    // aborts and a switched-off converter leave the old result in place.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            result_reg <= 12'h000;
        end
        else if (done && main_reg[`ADCC_MAIN_EN])
        begin
            result_reg <= conv_data;
        end
    end

    // Presentation follows the alignment bit combinationally.
    // alignment re-presents
    always_comb
    begin
        if (main_reg[`ADCC_MAIN_ALIGN])
        begin
            res_hi = {4'h0, result_reg[11:8]};
            res_lo = result_reg[7:0];
        end
        else
        begin
            res_hi = result_reg[11:4];
            res_lo = {result_reg[3:0], 4'h0};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Completion interrupt; set wins over the clear by read.
    // A read of the status register clears it, and a completion in that
    // same cycle is kept so that no event is lost.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_stat_reg <= 1'b0;
        end
        else if (done && main_reg[`ADCC_MAIN_EN])
        begin
            irq_stat_reg <= 1'b1;
        end
        else if (req.rd && req.addr == `ADCC_ADDR_IRQ_STAT)
        begin
            irq_stat_reg <= 1'b0;
        end
    end

    // Level output: high while the unmasked status bit is set.
    assign irq = irq_stat_reg && irq_mask_reg;

    //////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe.
    // The word stands for the one cycle after the strobe and is zero
    // otherwise; reads have no side effect except on the status.
    always_ff @(posedge clk)
    begin
        if (!rst_n || !req.rd)
        begin
            rdata <= 8'h00;
        end
        else if (req.addr == `ADCC_ADDR_RES_LO)
        begin
            // Low byte in the selected alignment.
            rdata <= res_lo;
        end
        else if (req.addr == `ADCC_ADDR_RES_HI)
        begin
            // High byte in the selected alignment.
            rdata <= res_hi;
        end
        else if (req.addr == `ADCC_ADDR_MAIN)
        begin
            // Busy comes from the sequencer, not the stored byte.
            rdata <= {main_reg[7], busy_reg, main_reg[5:0]};
        end
        else if (req.addr == `ADCC_ADDR_SRC)
        begin
            // Source and clock divider fields.
            rdata <= src_reg;
        end
        else if (req.addr == `ADCC_ADDR_REF)
        begin
            rdata <= ref_reg;
        end
        else if (req.addr == `ADCC_ADDR_BGAP)
        begin
            rdata <= bgap_reg;
        end
        else if (req.addr == `ADCC_ADDR_IRQ_STAT)
        begin
            rdata <= {7'h00, irq_stat_reg};
        end
        else if (req.addr == `ADCC_ADDR_IRQ_MASK)
        begin
            rdata <= {7'h00, irq_mask_reg};
        end
        else
        begin
            // Unmapped addresses read zero.
            rdata <= 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Analog front-end controls.
    // Codes of the source field that pick an internal signal carry the
    // signal's number in their low three bits; every other code leaves
    // the external channel in charge.
    always_comb
    begin
        mux.internal_code = 3'h0;
        mux.internal_sel = 1'b0;
        case (source)
            4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7:
            begin
                mux.internal_sel = 1'b1;
                mux.internal_code = source[2:0];
            end
            default:
            begin
                mux.internal_sel = 1'b0;
            end
        endcase
        mux.ext_connect = (main_reg[`ADCC_MAIN_EN] && !mux.internal_sel) ?
            16'(17'h00001 << main_reg[3:0]) : 16'h0000;
    end

    // Pins set up as analog inputs give up their digital driver and
    // their pull-high at once.
    // analog pins lose digital
    assign pin_digital_off = pin_analog_cfg;
    assign pin_pullup_off = pin_analog_cfg;
    // Outputs toward the analog core; all but conv_sample come straight from registers.
    assign conv_power = main_reg[`ADCC_MAIN_EN];
    assign conv_sample = tick;
    assign ref_cfg = ref_reg;
    assign bandgap_enable = bgap_reg[0];

endmodule : adcc_top

// ### tb/adcc_monitor.sv
`timescale 1ns/1ps
module adcc_monitor
    import adcc_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire adcc_req_type req, // Register request.
    input wire logic [7:0] rdata, // Read data.
    input wire logic [15:0] pin_analog_cfg, // Analog pins.
    input wire adcc_mux_type mux, // Mux controls.
    input wire logic [15:0] pin_digital_off, // Digital function off.
    input wire logic [15:0] pin_pullup_off, // Pull-up off.
    input wire logic conv_power, // Converter power.
    input wire logic conv_sample, // Converter clock pulse.
    input wire logic irq // Interrupt level.
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_pin_digital: assert property (pin_digital_off == pin_analog_cfg)
        else $error("digital function kept on analog pin");
    a_pin_pullup: assert property (pin_pullup_off == pin_analog_cfg)
        else $error("pull-up kept on analog pin");
    a_int_disc: assert property (mux.internal_sel |-> !mux.ext_connect)
        else $error("external channel left on with internal source");
    a_ext_onehot: assert property (|mux.ext_connect |->
        $onehot(mux.ext_connect))
        else $error("more than one external channel connected");
    a_power_en: assert property (req.wr && req.addr == 4'h2 |=>
        conv_power == $past(req.wdata[5]))
        else $error("converter power does not follow enable bit");
    a_sample_off: assert property ($past(!conv_power) && !conv_power
        |-> !conv_sample)
        else $error("converter clock runs while switched off");
    a_src_map: assert property (req.wr && req.addr == 4'h3 |=>
        mux.internal_sel == (!$past(req.wdata[7]) &&
        $past(req.wdata[5:4]) != 2'h0))
        else $error("source code picks wrong signal kind");
    a_irq_hold: assert property (irq && !req.rd && !req.wr |=> irq)
        else $error("interrupt dropped without a read");
    a_rd_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data driven outside read answer cycle");
endmodule : adcc_monitor

bind adcc_top adcc_monitor u_mon (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .pin_analog_cfg(pin_analog_cfg), .mux(mux),
    .pin_digital_off(pin_digital_off), .pin_pullup_off(pin_pullup_off),
    .conv_power(conv_power), .conv_sample(conv_sample), .irq(irq));

// ### tb/adcc_analog_model.sv
`timescale 1ns/1ps
module adcc_analog_model
    import adcc_pkg::*;
(
    clk, // System clock.
    mux, // Mux controls.
    conv_data // Converted value.
);
    input wire logic clk;
    input wire adcc_mux_type mux;
    output logic [11:0] conv_data;
    // Changing filler, 5A5 and A5B in turn; A5B matches channel 11's real data.
    logic [11:0] churn_reg = 12'h5A5;

    // Plain process: the seed above is this variable's only other writer.
    always @(posedge clk)
    begin
        churn_reg <= ~churn_reg + 12'h001;
    end

    // Internal source gives a fixed code, a channel its number.
    always_comb
    begin
        conv_data = churn_reg;
        if (mux.internal_sel)
            conv_data = 12'h5C3;
        for (int i = 0; i < 16; i++)
            if (mux.ext_connect[i])
                conv_data = {8'hA5, 4'(i)};
    end
endmodule : adcc_analog_model

// ### tb/tb_adcc_top.sv
`timescale 1ns/1ps
module tb_adcc_top import adcc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    adcc_req_type req = '0;
    logic [15:0] pin_cfg = 16'hA5C3;
    logic [7:0] rdata;
    logic [11:0] conv_data;
    adcc_mux_type mux;
    logic conv_sample;
    logic conv_power;
    logic irq;
    logic [7:0] ref_cfg;
    logic bgap_en;
    int bad_count = 0;
    int compares = 0;

    adcc_top dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .conv_data(conv_data), .pin_analog_cfg(pin_cfg), .mux(mux),
        .pin_digital_off(), .pin_pullup_off(), .conv_power(conv_power),
        .conv_sample(conv_sample), .ref_cfg(ref_cfg),
        .bandgap_enable(bgap_en), .irq(irq));
    adcc_analog_model far (.clk(clk), .mux(mux), .conv_data(conv_data));

    initial forever #2.5 clk = ~clk;

    task chk(input string n, input logic [15:0] s, e);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : wr

    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask : rd

    task res(input logic a, input logic [11:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(4'h0, lo);
        rd(4'h1, hi);
        chk("result", {hi, lo}, a ? {4'h0, v} : {v, 4'h0});
    endtask : res

    // Start, check busy, time the converter clock, poll to the end.
    task conv(input logic [7:0] m, output int gap);
        logic [7:0] d;
        int last;
        gap = 0;
        last = -1;
        wr(4'h2, m | 8'h80);
        rd(4'h2, d);
        chk("armed", d[6], 1'b0);
        wr(4'h2, m);
        rd(4'h2, d);
        chk("busy", d[6], 1'b1);
        for (int t = 0; t < 3000 && gap == 0; t++)
        begin
            @(posedge clk);
            #1;
            if (conv_sample === 1'b1)
            begin
                if (last >= 0)
                    gap = t - last;
                last = t;
            end
        end
        for (int t = 0; t < 2000 && d[6] !== 1'b0; t++)
            rd(4'h2, d);
        chk("done", d[6], 1'b0);
    endtask : conv

    task end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial
    begin
        // About three times the cycles that the scenarios need.
        #200000;
        bad_count++;
        end_sim;
    end

    initial
    begin
        int g;
        logic [7:0] d;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 13; a++)
        begin
            rd(4'(a), d);
            chk("reset", d, 8'h00);
        end
        wr(4'h7, 8'h01);
        wr(4'h2, 8'h20);
        // Every channel, every clock divider, interrupt each time.
        for (int c = 0; c < 16; c++)
        begin
            wr(4'h3, {5'h00, 3'(c)});
            conv({4'h2, 4'(c)}, g);
            chk("gap", 16'(g), 16'h1 << c[2:0]);
            res(1'b0, {8'hA5, 4'(c)});
            chk("irq", irq, 1'b1);
            rd(4'h6, d);
            chk("status", d, 8'h01);
            chk("irq_clr", irq, 1'b0);
        end
        wr(4'h2, 8'h3F);
        res(1'b1, 12'hA5F);
        conv(8'h35, g);
        res(1'b1, 12'hA55);
        rd(4'h6, d);
        wr(4'h2, 8'h75);
        rd(4'h2, d);
        chk("busy_ro", d, 8'h35);
        // Abort mid-conversion, then a start while switched off.
        wr(4'h2, 8'hB5);
        wr(4'h2, 8'h35);
        wr(4'h2, 8'hB5);
        rd(4'h2, d);
        chk("abort", d[6], 1'b0);
        wr(4'h2, 8'h9A);
        #1;
        chk("power", conv_power, 1'b0);
        wr(4'h2, 8'h1A);
        repeat (2100) @(posedge clk);
        rd(4'h6, d);
        chk("no_done", d, 8'h00);
        res(1'b1, 12'hA55);
        for (int c = 0; c < 16; c++)
        begin
            wr(4'h3, {4'(c), 4'h7});
            pin_cfg <= {4{4'(c)}};
            #1;
            chk("int_sel", mux.internal_sel, !c[3] && c[1:0] != 2'h0);
        end
        // Switch on first: a start in the enabling write is not seen.
        wr(4'h3, 8'h10);
        wr(4'h2, 8'h35);
        wr(4'h7, 8'h00);
        conv(8'h35, g);
        res(1'b1, 12'h5C3);
        chk("irq_mask", irq, 1'b0);
        rd(4'h6, d);
        chk("masked", d, 8'h01);
        // Reference and bandgap settings pass to the analog core.
        wr(4'h4, 8'hFF);
        wr(4'h5, 8'hFF);
        rd(4'h4, d);
        chk("ref_rd", d, 8'h9F);
        rd(4'h5, d);
        chk("bgap_rd", d, 8'h01);
        chk("ref_out", ref_cfg, 8'h9F);
        chk("bgap_out", bgap_en, 1'b1);
        end_sim;
    end
endmodule : tb_adcc_top
